// ---- emx_strobe_arb.sv ----
// External memory strobe muxing, chip space select, clocking and bus hold arbitration
`timescale 1ns/1ps
`default_nettype none
`include "emx_defines.svh"

// Notes on behaviour
// - Interface clock source picked at reset from pin, core/4 or core/6 via straps.
// - Straps not selecting a core division leave the external clock pin as source.
// - Divided output clock runs at interface clock over one, two or four.
// - Full-rate output clock always follows the selected interface clock.
// - Shared read pin: async read, SDRAM column strobe, sync address or read strobe.
// - Sync spaces: select bit 0 gives address strobe, 1 gives read enable.
// - Shared enable pin: async output enable, SDRAM row strobe, sync output enable.
// - Shared write pin is write enable for every memory type of the space.
// - SDRAM clock enable output drops to put SDRAM in self-refresh.
// - Without SDRAM, software may drive the clock enable pin as plain output.
// - Dedicated FIFO output enable asserts only for synchronous reads of space three.
// - Hold grant output rises once the device has released the bus.
// - Pending request output shows accesses waiting for the external bus.
// - Async memory drives ready; the device samples it to finish accesses.
// - Word address bits 28 and 29 pick one of four spaces; one enable only.
module emx_strobe_arb
  import emx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register bus
  input  wire logic [31:0] s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [31:0] s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  // Internal access requests
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [31:0] reqWordAddr,
  output logic             reqReady,
  output logic             accessDone,
  // Clocking
  input  wire logic        extIfaceClkIn,
  input  wire logic [1:0]  clockSourceStraps,
  output logic             fullRateIfaceClkOut,
  output logic             dividedIfaceClkOut,
  // Memory control pins, all strobes active low
  output logic             sharedReadStrobe_n,
  output logic             sharedOutputEnable_n,
  output logic             sharedWriteStrobe_n,
  output logic [3:0]       chipSpaceSelect_n,
  output logic             fifoSpaceOutputEnable_n,
  output logic             busPinsOe,
  output logic             sdramClkEnableOut,
  input  wire logic        asyncMemReadyIn,
  // Bus arbitration
  input  wire logic        hostBusClaimIn,
  output logic             holdGrantOut,
  output logic             pendingAccessRequestOut
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    emx_state_t    state;
    logic [1:0]    space;
    logic          isWrite;
    emx_mem_type_t memType;
    logic          readSel;
    logic          readySample;
    logic          done;
    logic          readStrobe_n;
    logic          outEnable_n;
    logic          writeStrobe_n;
    logic [3:0]    select_n;
    logic          fifoOe_n;
    logic          pinsOe;
    logic          grant;
    logic          pending;
    logic          cke;
  } emx_arb_state_t;

  emx_arb_state_t s;
  emx_arb_state_t next_s;

  logic           ifaceTick;
  emx_clk_src_t   clkSource;
  logic [31:0]    ctrlWord;
  logic [31:0]    spaceWord;
  logic [31:0]    statusWord;
  emx_div_ratio_t divRatio;

  assign divRatio = emx_div_ratio_t'(ctrlWord[`EMX_CTRL_DIV_MSB:`EMX_CTRL_DIV_LSB]);

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  emx_clk_gen u_clk_gen (
    .clk                 (clk),
    .rst_n               (rst_n),
    .extIfaceClkIn       (extIfaceClkIn),
    .clockSourceStraps   (clockSourceStraps),
    .divRatio            (divRatio),
    .ifaceTick           (ifaceTick),
    .fullRateIfaceClkOut (fullRateIfaceClkOut),
    .dividedIfaceClkOut  (dividedIfaceClkOut),
    .clkSource           (clkSource)
  );

  emx_axil_regs u_regs (
    .clk            (clk),
    .rst_n          (rst_n),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .statusWord     (statusWord),
    .ctrlWord       (ctrlWord),
    .spaceWord      (spaceWord)
  );

  always_comb
  begin
    statusWord = 32'h0;
    statusWord[`EMX_STAT_SRC_MSB:`EMX_STAT_SRC_LSB] = clkSource;
    statusWord[`EMX_STAT_GRANT]   = s.grant;
    statusWord[`EMX_STAT_PENDING] = s.pending;
    statusWord[`EMX_STAT_BUSY]    = (s.state != EMX_IDLE) && (s.state != EMX_GRANT);
  end

  // --------------------------------------------------------------------------
  // Access sequencing and arbitration
  // --------------------------------------------------------------------------
  // A host claim is honoured only between accesses, so an access in flight always completes
  assign reqReady = (s.state == EMX_IDLE) && !hostBusClaimIn;

  always_comb
  begin
    logic active;
    active             = 1'b0;
    next_s             = s;
    next_s.done        = 1'b0;
    next_s.readySample = asyncMemReadyIn;
    unique case (s.state)
      EMX_IDLE:
      begin
        if (hostBusClaimIn)
        begin
          next_s.state = EMX_GRANT;
        end
        else if (reqValid)
        begin
          next_s.state   = EMX_SETUP;
          next_s.space   = reqWordAddr[29:28];
          next_s.isWrite = reqWrite;
          next_s.memType = emxMemTypeOf(spaceWord, reqWordAddr[29:28]);
          next_s.readSel = spaceWord[`EMX_SPACE_REN_LSB + reqWordAddr[29:28]];
        end
      end
      EMX_SETUP:
      begin
        if (ifaceTick)
        begin
          next_s.state = EMX_STROBE;
        end
      end
      EMX_STROBE:
      begin
        // Async strobe is held until ready has been seen high at an interface tick
        if (ifaceTick && (s.memType != EMX_MEM_ASYNC || s.readySample))
        begin
          next_s.state = EMX_FINISH;
        end
      end
      EMX_FINISH:
      begin
        if (ifaceTick)
        begin
          next_s.state = EMX_IDLE;
          next_s.done  = 1'b1;
        end
      end
      EMX_GRANT:
      begin
        if (!hostBusClaimIn)
        begin
          next_s.state = EMX_IDLE;
        end
      end
      default:
      begin
        next_s.state = EMX_IDLE;
      end
    endcase

    // Pin values follow the next state so they change in step with it
    active = (next_s.state == EMX_SETUP) || (next_s.state == EMX_STROBE) ||
             (next_s.state == EMX_FINISH);
    next_s.readStrobe_n  = 1'b1;
    next_s.outEnable_n   = 1'b1;
    next_s.writeStrobe_n = 1'b1;
    next_s.fifoOe_n      = 1'b1;
    next_s.select_n      = 4'hf;
    if (active)
    begin
      next_s.select_n[next_s.space] = 1'b0;
    end
    if (next_s.state == EMX_SETUP)
    begin
      if (next_s.memType == EMX_MEM_SDRAM)
      begin
        next_s.outEnable_n = 1'b0;
      end
      if (next_s.memType == EMX_MEM_SYNC && !next_s.readSel)
      begin
        next_s.readStrobe_n = 1'b0;
      end
    end
    if (next_s.state == EMX_STROBE)
    begin
      unique case (next_s.memType)
        EMX_MEM_SDRAM:
        begin
          next_s.readStrobe_n  = 1'b0;
          next_s.writeStrobe_n = !next_s.isWrite;
        end
        EMX_MEM_SYNC:
        begin
          next_s.writeStrobe_n = !next_s.isWrite;
          next_s.outEnable_n   = next_s.isWrite;
          next_s.readStrobe_n  = !(next_s.readSel && !next_s.isWrite);
          next_s.fifoOe_n      = !(!next_s.isWrite && next_s.space == 2'h3);
        end
        default:
        begin
          next_s.readStrobe_n  = next_s.isWrite;
          next_s.outEnable_n   = next_s.isWrite;
          next_s.writeStrobe_n = !next_s.isWrite;
        end
      endcase
    end
    next_s.grant   = (next_s.state == EMX_GRANT);
    next_s.pinsOe  = !next_s.grant;
    next_s.pending = reqValid || active;
    // General-purpose mode wins over self-refresh when no SDRAM is fitted
    if (ctrlWord[`EMX_CTRL_GPO_MODE])
    begin
      next_s.cke = ctrlWord[`EMX_CTRL_GPO_VALUE];
    end
    else
    begin
      next_s.cke = !ctrlWord[`EMX_CTRL_SELF_REF];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s               <= '0;
      s.readStrobe_n  <= 1'b1;
      s.outEnable_n   <= 1'b1;
      s.writeStrobe_n <= 1'b1;
      s.select_n      <= 4'hf;
      s.fifoOe_n      <= 1'b1;
      s.pinsOe        <= 1'b1;
      s.cke           <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign accessDone              = s.done;
  assign sharedReadStrobe_n      = s.readStrobe_n;
  assign sharedOutputEnable_n    = s.outEnable_n;
  assign sharedWriteStrobe_n     = s.writeStrobe_n;
  assign chipSpaceSelect_n       = s.select_n;
  assign fifoSpaceOutputEnable_n = s.fifoOe_n;
  assign busPinsOe               = s.pinsOe;
  assign sdramClkEnableOut       = s.cke;
  assign holdGrantOut            = s.grant;
  assign pendingAccessRequestOut = s.pending;

endmodule : emx_strobe_arb
`default_nettype wire

// ---- emx_defines.svh ----
// Offsets, field positions, reset values and divider counts for the external memory strobe block
`ifndef EMX_DEFINES_SVH
`define EMX_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define EMX_OFF_CTRL        4'h0
`define EMX_OFF_SPACE       4'h4
`define EMX_OFF_STATUS      4'h8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define EMX_CTRL_DIV_LSB    0
`define EMX_CTRL_DIV_MSB    1
`define EMX_CTRL_GPO_MODE   2
`define EMX_CTRL_GPO_VALUE  3
`define EMX_CTRL_SELF_REF   4
`define EMX_CTRL_MASK       32'h0000001f

// ----------------------------------------------------------------------------
// Space configuration fields: type at [2i+1:2i], read strobe select at 8+i
// ----------------------------------------------------------------------------
`define EMX_SPACE_REN_LSB   8
`define EMX_SPACE_MASK      32'h00000fff

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define EMX_STAT_SRC_LSB    0
`define EMX_STAT_SRC_MSB    1
`define EMX_STAT_GRANT      2
`define EMX_STAT_PENDING    3
`define EMX_STAT_BUSY       4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define EMX_CTRL_RST        32'h00000000
`define EMX_SPACE_RST       32'h00000000

// ----------------------------------------------------------------------------
// Core clock divider counts and strap codes
// ----------------------------------------------------------------------------
`define EMX_CORE_DIV4       3'h4
`define EMX_CORE_DIV6       3'h6
`define EMX_STRAP_DIV4      2'h1
`define EMX_STRAP_DIV6      2'h2

`endif

// ---- emx_pkg.sv ----
// Types and shared decode functions of the external memory strobe block
`default_nettype none
package emx_pkg;

  typedef enum logic [1:0] {
    EMX_MEM_ASYNC = 2'b00,
    EMX_MEM_SDRAM = 2'b01,
    EMX_MEM_SYNC  = 2'b10,
    EMX_MEM_RSVD  = 2'b11
  } emx_mem_type_t;

  typedef enum logic [1:0] {
    EMX_SRC_EXT  = 2'b00,
    EMX_SRC_DIV4 = 2'b01,
    EMX_SRC_DIV6 = 2'b10
  } emx_clk_src_t;

  typedef enum logic [1:0] {
    EMX_DIV1 = 2'b00,
    EMX_DIV2 = 2'b01,
    EMX_DIV4 = 2'b10,
    EMX_DIV4_ALT = 2'b11
  } emx_div_ratio_t;

  typedef enum logic [2:0] {
    EMX_IDLE   = 3'b000,
    EMX_SETUP  = 3'b001,
    EMX_STROBE = 3'b010,
    EMX_FINISH = 3'b011,
    EMX_GRANT  = 3'b100
  } emx_state_t;

  // Reserved type code behaves as asynchronous memory
  function automatic emx_mem_type_t emxMemTypeOf(input logic [31:0] cfg, input logic [1:0] idx);
    logic [1:0] code;
    code = cfg[{idx, 1'b0} +: 2];
    emxMemTypeOf = (code == 2'b11) ? EMX_MEM_ASYNC : emx_mem_type_t'(code);
  endfunction : emxMemTypeOf

  function automatic logic [31:0] emxApplyStrobe(input logic [31:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    emxApplyStrobe = res;
  endfunction : emxApplyStrobe

endpackage : emx_pkg
`default_nettype wire

// ---- emx_clk_gen.sv ----
// Interface clock source choice, full-rate and divided output clocks
`timescale 1ns/1ps
`default_nettype none
`include "emx_defines.svh"

module emx_clk_gen
  import emx_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           extIfaceClkIn,
  input  wire logic [1:0]     clockSourceStraps,
  input  wire emx_div_ratio_t divRatio,
  output logic                ifaceTick,
  output logic                fullRateIfaceClkOut,
  output logic                dividedIfaceClkOut,
  output emx_clk_src_t        clkSource
);

  typedef struct packed {
    logic         strapsTaken;
    emx_clk_src_t src;
    logic [2:0]   cnt;
    logic         extLevel;
    logic [1:0]   divCnt;
    logic         tick;
    logic         fullOut;
    logic         divOut;
  } emx_clk_state_t;

  emx_clk_state_t s;
  emx_clk_state_t next_s;

  always_comb
  begin
    logic [2:0] limit;
    limit  = `EMX_CORE_DIV4;
    next_s = s;
    // Straps cannot be loaded under async reset, so take them at the first edge after release
    if (!s.strapsTaken)
    begin
      next_s.strapsTaken = 1'b1;
      unique case (clockSourceStraps)
        `EMX_STRAP_DIV4: next_s.src = EMX_SRC_DIV4;
        `EMX_STRAP_DIV6: next_s.src = EMX_SRC_DIV6;
        default:         next_s.src = EMX_SRC_EXT;
      endcase
    end
    next_s.extLevel = extIfaceClkIn;
    if (s.src == EMX_SRC_DIV6)
    begin
      limit = `EMX_CORE_DIV6;
    end
    if (s.src == EMX_SRC_EXT)
    begin
      next_s.tick    = extIfaceClkIn & ~s.extLevel;
      next_s.fullOut = extIfaceClkIn;
      next_s.cnt     = 3'h0;
    end
    else
    begin
      next_s.tick = (s.cnt == limit - 3'h1);
      next_s.cnt  = next_s.tick ? 3'h0 : s.cnt + 3'h1;
      next_s.fullOut = (next_s.cnt < (limit >> 1));
    end
    if (next_s.tick)
    begin
      next_s.divCnt = s.divCnt + 2'h1;
    end
    unique case (divRatio)
      EMX_DIV1: next_s.divOut = next_s.fullOut;
      EMX_DIV2: next_s.divOut = next_s.divCnt[0];
      default:  next_s.divOut = next_s.divCnt[1];
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign ifaceTick           = s.tick;
  assign fullRateIfaceClkOut = s.fullOut;
  assign dividedIfaceClkOut  = s.divOut;
  assign clkSource           = s.src;

endmodule : emx_clk_gen
`default_nettype wire

// ---- emx_axil_regs.sv ----
// AXI4-Lite register slave: control, space configuration and status words
`timescale 1ns/1ps
`default_nettype none
`include "emx_defines.svh"

module emx_axil_regs
  import emx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [31:0] s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic [31:0] statusWord,
  output logic [31:0]      ctrlWord,
  output logic [31:0]      spaceWord
);

  typedef struct packed {
    logic        awHeld;
    logic [31:0] awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [31:0] ctrl;
    logic [31:0] space;
  } emx_reg_state_t;

  emx_reg_state_t s;
  emx_reg_state_t next_s;

  function automatic logic isMapped(input logic [31:0] addr);
    isMapped = (addr[31:4] == 28'h0) && (addr[3:0] == `EMX_OFF_CTRL ||
               addr[3:0] == `EMX_OFF_SPACE || addr[3:0] == `EMX_OFF_STATUS);
  endfunction : isMapped

  assign s_axil_awready = !s.awHeld && !s.bValid;
  assign s_axil_wready  = !s.wHeld && !s.bValid;
  assign s_axil_arready = !s.rValid;

  always_comb
  begin
    next_s = s;
    if (s_axil_awvalid && s_axil_awready)
    begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready)
    begin
      next_s.wHeld = 1'b1;
      next_s.wData = s_axil_wdata;
      next_s.wStrb = s_axil_wstrb;
    end
    if (s.bValid && s_axil_bready)
    begin
      next_s.bValid = 1'b0;
    end
    // Write commits once both halves are in, whichever came first
    if (s.awHeld && s.wHeld)
    begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = isMapped(s.awAddr) ? 2'b00 : 2'b10;
      if (isMapped(s.awAddr) && s.awAddr[3:0] == `EMX_OFF_CTRL)
      begin
        next_s.ctrl = emxApplyStrobe(s.ctrl, s.wData, s.wStrb) & `EMX_CTRL_MASK;
      end
      if (isMapped(s.awAddr) && s.awAddr[3:0] == `EMX_OFF_SPACE)
      begin
        next_s.space = emxApplyStrobe(s.space, s.wData, s.wStrb) & `EMX_SPACE_MASK;
      end
    end
    if (s.rValid && s_axil_rready)
    begin
      next_s.rValid = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready)
    begin
      next_s.rValid = 1'b1;
      next_s.rResp  = isMapped(s_axil_araddr) ? 2'b00 : 2'b10;
      next_s.rData  = 32'h0;
      if (isMapped(s_axil_araddr))
      begin
        unique case (s_axil_araddr[3:0])
          `EMX_OFF_CTRL:  next_s.rData = s.ctrl;
          `EMX_OFF_SPACE: next_s.rData = s.space;
          default:        next_s.rData = statusWord;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s       <= '0;
      s.ctrl  <= `EMX_CTRL_RST;
      s.space <= `EMX_SPACE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axil_bvalid = s.bValid;
  assign s_axil_bresp  = s.bResp;
  assign s_axil_rvalid = s.rValid;
  assign s_axil_rdata  = s.rData;
  assign s_axil_rresp  = s.rResp;
  assign ctrlWord      = s.ctrl;
  assign spaceWord     = s.space;

endmodule : emx_axil_regs
`default_nettype wire

// ---- emx_strobe_arb_monitor.sv ----
// Pin checker of the strobe, select and hold behaviour
`timescale 1ns/1ps
`default_nettype none
module emx_strobe_arb_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reqValid,
  input wire logic       reqReady,
  input wire logic [3:0] chipSpaceSelect_n,
  input wire logic       fifoSpaceOutputEnable_n,
  input wire logic       busPinsOe,
  input wire logic       hostBusClaimIn,
  input wire logic       holdGrantOut,
  input wire logic       pendingAccessRequestOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_hold_floats: assert property (holdGrantOut |-> !busPinsOe)
    else $error("pins driven in hold");
  a_hold_blocks: assert property (holdGrantOut |-> !reqReady)
    else $error("request open in hold");
  a_grant_cause: assert property ($rose(holdGrantOut) |-> $past(hostBusClaimIn))
    else $error("grant without claim");
  a_grant_drop: assert property (holdGrantOut && !hostBusClaimIn |=> !holdGrantOut)
    else $error("grant kept");
  a_take_space: assert property (reqValid && reqReady |=> chipSpaceSelect_n != 4'hf)
    else $error("no space select");
  a_one_space: assert property ($onehot0(~chipSpaceSelect_n))
    else $error("two space selects");
  a_fifo_space: assert property (!fifoSpaceOutputEnable_n |-> chipSpaceSelect_n == 4'h7)
    else $error("fifo enable off space 3");
  a_pending_req: assert property (reqValid |=> pendingAccessRequestOut)
    else $error("pending low");
endmodule : emx_strobe_arb_monitor
bind emx_strobe_arb emx_strobe_arb_monitor emx_strobe_arb_monitor_inst (.*);
`default_nettype wire

// ---- emx_mem_model.sv ----
// Asynchronous memory whose ready line lags the strobe by a set time
`timescale 1ns/1ps
`default_nettype none
module emx_mem_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       strobe_n,
  input  wire logic [7:0] waitCycles,
  output logic            asyncMemReadyIn
);
  logic [7:0] busyCount;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n || strobe_n)
      busyCount <= 8'h00;
    else if (busyCount != 8'hff)
      busyCount <= busyCount + 8'h01;
  end
  // Pull-up holds ready high outside a strobe
  assign asyncMemReadyIn = strobe_n || (busyCount >= waitCycles);
endmodule : emx_mem_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the strobe, clock and hold block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, extIfaceClkIn = 1'h0, hostBusClaimIn = 1'h0;
  logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0, reqValid = 1'h0;
  logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0, reqWrite = 1'h0, ta, tw;
  logic [31:0] s_axil_awaddr = '0, s_axil_wdata = '0, s_axil_araddr = '0, reqWordAddr = '0;
  logic [31:0] s_axil_rdata, rdv;
  logic [3:0] s_axil_wstrb = 4'hf, chipSpaceSelect_n;
  logic [1:0] clockSourceStraps = 2'h2, s_axil_bresp, s_axil_rresp, rsp, s;
  logic [7:0] waitCycles = 8'h00, seen;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic reqReady, accessDone, fullRateIfaceClkOut, dividedIfaceClkOut, busPinsOe;
  logic sharedReadStrobe_n, sharedOutputEnable_n, sharedWriteStrobe_n, holdGrantOut;
  logic fifoSpaceOutputEnable_n, sdramClkEnableOut, asyncMemReadyIn, pendingAccessRequestOut;
  int miscompares = 0, num_checks = 0, cyc = 0, n;
  always #5 clk = ~clk;
  always #40 extIfaceClkIn = ~extIfaceClkIn;
  emx_strobe_arb emx_strobe_arb_inst (.*);
  emx_mem_model emx_mem_model_inst (.clk, .rst_n, .waitCycles, .asyncMemReadyIn,
    .strobe_n(sharedReadStrobe_n & sharedWriteStrobe_n));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  always @(posedge clk) if (++cyc == 20000)
  begin
    miscompares++;
    summarize();
  end
  task rst(input logic [1:0] st);
    clockSourceStraps <= st;
    rst_n <= 1'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
  endtask : rst
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axil_awaddr, s_axil_wdata} <= {a, d};
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    do begin
      @(negedge clk);
      ta = s_axil_awvalid & s_axil_awready;
      tw = s_axil_wvalid & s_axil_wready;
      @(posedge clk);
      if (ta) s_axil_awvalid <= 1'h0;
      if (tw) s_axil_wvalid <= 1'h0;
    end while ((s_axil_awvalid && !ta) || (s_axil_wvalid && !tw));
    do @(negedge clk); while (s_axil_bvalid !== 1'h1);
    chk("bresp", 2'h0, s_axil_bresp);
    @(posedge clk);
    s_axil_bready <= 1'h0;
  endtask : wr
  task rd(input logic [31:0] a);
    @(posedge clk);
    {s_axil_araddr, s_axil_arvalid, s_axil_rready} <= {a, 2'h3};
    do @(negedge clk); while (s_axil_arready !== 1'h1);
    @(posedge clk);
    s_axil_arvalid <= 1'h0;
    do @(negedge clk); while (s_axil_rvalid !== 1'h1);
    {rdv, rsp} = {s_axil_rdata, s_axil_rresp};
    @(posedge clk);
    s_axil_rready <= 1'h0;
  endtask : rd
  // Collects which strobes and selects went low during one access
  task acc(input logic w, input logic [31:0] a);
    @(posedge clk);
    {reqWrite, reqWordAddr, reqValid} <= {w, a, 1'h1};
    seen = 8'hff;
    n = 0;
    do @(negedge clk); while (reqReady !== 1'h1);
    @(posedge clk);
    reqValid <= 1'h0;
    do begin
      @(negedge clk);
      n++;
      seen &= {sharedReadStrobe_n, sharedOutputEnable_n, sharedWriteStrobe_n,
               fifoSpaceOutputEnable_n, chipSpaceSelect_n};
    end while (accessDone !== 1'h1 && n < 200);
    chk("done", 1'h1, accessDone);
  endtask : acc
  task clks(input logic [1:0] dv, input int e);
    int f, d;
    wr(32'h0, {30'h0, dv});
    {f, d} = {32'h0, 32'h0};
    repeat (16) @(negedge clk);
    repeat (400)
    begin
      {ta, tw} = {fullRateIfaceClkOut, dividedIfaceClkOut};
      @(negedge clk);
      f += fullRateIfaceClkOut & !ta;
      d += dividedIfaceClkOut & !tw;
    end
    chk("full rate", 1, f > 98 && f < 102);
    chk("divided", 1, d >= e - 1 && d <= e + 1);
  endtask : clks
  task hold;
    @(posedge clk);
    hostBusClaimIn <= 1'h1;
    repeat (3) @(negedge clk);
    chk("grant", 3'h4, {holdGrantOut, busPinsOe, reqReady});
    @(posedge clk);
    hostBusClaimIn <= 1'h0;
    repeat (2) @(negedge clk);
    chk("release", 2'h1, {holdGrantOut, busPinsOe});
  endtask : hold
  task cke(input logic [31:0] c, input logic e);
    wr(32'h0, c);
    repeat (2) @(negedge clk);
    chk("cke", e, sdramClkEnableOut);
  endtask : cke
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      s = 2'(i + 2);
      rst(s);
      rd(32'h8);
      chk("source", (s == 2'h3) ? 2'h0 : s, rdv[1:0]);
    end
    rd(32'h0);
    chk("ctrl rst", 32'h0, rdv);
    rd(32'hc);
    chk("unmapped resp", 2'h2, rsp);
    chk("unmapped data", 32'h0, rdv);
    wr(32'h4, 32'h8a4);
    acc(1'h0, 32'h0);
    chk("async rd", 8'h3e, seen);
    waitCycles <= 8'h14;
    acc(1'h0, 32'h0);
    chk("stretch", 1, n > 20);
    acc(1'h0, 32'h30000000);
    chk("fifo rd", 8'h27, seen);
    acc(1'h1, 32'h10000000);
    chk("sdram wr", 8'h1d, seen);
    acc(1'h1, 32'h20000000);
    chk("sync wr", 8'h5b, seen);
    hold();
    for (int i = 0; i < 4; i++) clks(2'(i), (i == 0) ? 100 : (i == 1) ? 50 : 25);
    cke(32'h4, 1'h0);
    cke(32'hc, 1'h1);
    cke(32'h10, 1'h0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
